// ### hdl/slpg_blink.sv
// Shared phase-aligned blink and flicker divider
module slpg_blink
	import slpg_pkg::*;
#(
	parameter int unsigned QUARTER = QUARTER_CYC,
	parameter int unsigned FLICK   = FLICK_CYC
)
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// Patterns
	output logic      blink_1hz,
	output logic      blink_2hz,
	output logic      flicker,
	output logic      quarter_tick
);

	logic [CNT_W-1:0] q_cnt_reg;
	logic [CNT_W-1:0] f_cnt_reg;
	logic [1:0]       phase_reg;
	logic             flick_reg;
	logic             f_wrap;

	assign quarter_tick = (q_cnt_reg == CNT_W'(QUARTER - 32'h1));
	assign f_wrap       = (f_cnt_reg == CNT_W'(FLICK - 32'h1));
	assign blink_2hz    = ~phase_reg[0];
	assign blink_1hz    = ~phase_reg[1];
	assign flicker      = flick_reg;

	// Quarter-second base and phase
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			q_cnt_reg <= '0;
			phase_reg <= 2'h0;
		end
		else if (quarter_tick)
		begin
			q_cnt_reg <= '0;
			phase_reg <= phase_reg + 2'h1;
		end
		else
			q_cnt_reg <= q_cnt_reg + CNT_W'(1);
	end

	// R23 flicker realigned
	always_ff @(posedge ref_clk)
	begin
		if (rst || quarter_tick)
		begin
			f_cnt_reg <= '0;
			flick_reg <= 1'b1;
		end
		else if (f_wrap)
		begin
			f_cnt_reg <= '0;
			flick_reg <= ~flick_reg;
		end
		else
			f_cnt_reg <= f_cnt_reg + CNT_W'(1);
	end

	// R23 aligned rate check
	chk_blink_phase: assert property (@(posedge ref_clk) disable iff (rst) // R23
		!quarter_tick |=> $stable(blink_2hz) && $stable(blink_1hz))
		else $error("blink changed off the quarter tick");

endmodule : slpg_blink

// ### hdl/slpg_pkg.sv
// Constants, register map and state types of the status LED pattern generator
package slpg_pkg;

	// System clock and pattern timing
	localparam longint CLK_HZ         = 64'h0000_0000_02FA_F080;
	localparam longint MS_PER_S       = 64'h0000_0000_0000_03E8;
	localparam longint QUARTER_MS     = 64'h0000_0000_0000_00FA;
	localparam longint FLICK_MS       = 64'h0000_0000_0000_0019;
	localparam longint STARTUP_MIN_MS = 64'h0000_0000_0000_0BB8;

	// Cycles per quarter second (2 Hz half period) and per flicker half period
	localparam int unsigned QUARTER_CYC = int'(QUARTER_MS * CLK_HZ / MS_PER_S);
	localparam int unsigned FLICK_CYC   = int'(FLICK_MS * CLK_HZ / MS_PER_S);
	localparam int          CNT_W       = 24;

	// Least start-up display, in quarter ticks, rounded up plus one for the partial first tick
	localparam int unsigned STARTUP_TICKS =
		int'((STARTUP_MIN_MS + QUARTER_MS - 64'h1) / QUARTER_MS) + 32'h1;
	localparam int          STUP_W        = 5;

	// Channel counts
	localparam int DI_N = 16;
	localparam int DO_N = 12;
	localparam int PWR_N = 3;

	// Register port
	localparam int            ADDR_W   = 4;
	localparam int            DATA_W   = 32;
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_LEDS = 4'h4;
	localparam logic [ADDR_W-1:0] REG_DI   = 4'h8;
	localparam logic [ADDR_W-1:0] REG_DO   = 4'hC;
	localparam int            CTRL_LOG_BIT  = 0;
	localparam int            CTRL_TEST_BIT = 1;
	localparam int            CTRL_W        = 2;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;

	// Display sequencing states
	typedef enum logic [3:0] {
		ST_POWER_ON = 4'h1,
		ST_STARTUP  = 4'h2,
		ST_OPER     = 4'h4,
		ST_SPARE    = 4'h8
	} slpg_state_t;

	// Diagnostic logging states
	typedef enum logic [2:0] {
		LOG_IDLE    = 3'h1,
		LOG_WRITE   = 3'h2,
		LOG_RESTART = 3'h4
	} slpg_log_t;

endpackage : slpg_pkg

// ### hdl/slpg_sync3.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree
module slpg_sync3
	import slpg_pkg::*;
#(
	parameter int W = 1
)
(
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst,
	// Asynchronous levels in, settled levels out
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	// Shift chain; first stage feeds only the second
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end
		else
		begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Take each bit once the later two stages agree
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			sync_out <= '0;
		else
			sync_out <= (s2_reg & s3_reg) | (sync_out & (s2_reg | s3_reg));
	end

endmodule : slpg_sync3

// ### hdl/slpg_top.sv
// Status bar and I/O LED pattern generator for the controller front panel
// Overview of operation
// R1: After power-up, yellow blinks at 1 Hz.
// R2: Start-up blinks both greens at 2 Hz for at least 3 s.
// R3: Halted with nothing else shown lights yellow steadily.
// R4: Error state lights red steadily.
// R5: Running without error or diagnostics lights both greens.
// R6: Running with diagnostics: green on, red blinks 1 Hz.
// R7: Holding point reached: red on, green blinks 1 Hz.
// R8: Diagnostics during start-up: red 1 Hz, green 2 Hz.
// R9: System or internal error lights red and green steadily.
// R10: With card logging enabled, an error starts a card write, then restart.
// R11: Hardware configuration loading blinks yellow at 2 Hz.
// R12: Identification blink test blinks greens at 1 Hz.
// R13: Card access while running: one green on, other flickers.
// R14: Card access running with diagnostics: red 1 Hz, green flickers.
// R15: Card access while halted flickers yellow.
// R16: Overall reset: yellow 1 Hz requested, 2 Hz running, steady done.
// R17: Factory reset: yellow 2 Hz running, then red and yellow 1 Hz.
// R18: New firmware found: red and yellow blink in opposite phase, 1 Hz.
// R19: Firmware update blinks yellow 2 Hz, flickers during card access.
// R20: Update done: red and yellow 1 Hz together; failed: red 1 Hz.
// R21: Each input and output channel LED shows its channel level.
// R22: Fault LED shows output overload; supply LEDs show supplies present.
// R23: Shared aligned dividers make all blink and flicker patterns.
//
// Our own choices: the register addresses and strobed register access.
module slpg_top
	import slpg_pkg::*;
#(
	parameter int unsigned QUARTER = QUARTER_CYC,
	parameter int unsigned FLICK   = FLICK_CYC,
	parameter int          NDI     = DI_N,
	parameter int          NDO     = DO_N
)
(
	// Clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	// Register port
	input  wire logic [slpg_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [slpg_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [slpg_pkg::DATA_W-1:0] reg_rdata,
	// Controller core state indications
	input  wire logic                      core_startup,
	input  wire logic                      core_run,
	input  wire logic                      core_stop,
	input  wire logic                      core_error,
	input  wire logic                      core_sys_error,
	input  wire logic                      core_diag_pending,
	input  wire logic                      core_hold_point,
	input  wire logic                      card_access,
	input  wire logic                      hw_cfg_loading,
	input  wire logic                      mres_req,
	input  wire logic                      mres_exec,
	input  wire logic                      mres_done,
	input  wire logic                      fact_exec,
	input  wire logic                      fact_done,
	input  wire logic                      fw_new,
	input  wire logic                      fw_busy,
	input  wire logic                      fw_done_ok,
	input  wire logic                      fw_fail,
	// Diagnostic logging handshake
	input  wire logic                      card_write_done,
	output logic                           card_write_req,
	output logic                           core_restart,
	// Channel levels and supervision pins
	input  wire logic [NDI-1:0]            di_pin,
	input  wire logic [NDO-1:0]            do_level,
	input  wire logic                      output_section_return_fault_pin,
	input  wire logic                      electronics_supply_feed_pin,
	input  wire logic                      input_section_supply_feed_pin,
	input  wire logic                      output_section_supply_feed_pin,
	// Status bar LEDs
	output logic                           led_red,
	output logic                           led_yellow,
	output logic                           led_green_a,
	output logic                           led_green_b,
	// I/O and supply LEDs
	output logic      [NDI-1:0]            di_led,
	output logic      [NDO-1:0]            do_led,
	output logic                           output_section_return_led,
	output logic                           electronics_supply_feed_led,
	output logic                           input_section_supply_feed_led,
	output logic                           output_section_supply_feed_led
);

	slpg_state_t          st_reg;
	slpg_state_t          st_next;
	slpg_log_t            log_reg;
	slpg_log_t            log_next;
	logic [STUP_W-1:0]    stup_reg;
	logic [CTRL_W-1:0]    ctrl_reg;
	logic [DATA_W-1:0]    rdata_next;
	logic                 err_prev_reg;
	logic                 b1;
	logic                 b2;
	logic                 fl;
	logic                 qtick;
	logic                 stup_done;
	logic                 red_next;
	logic                 yel_next;
	logic                 ga_next;
	logic                 gb_next;
	logic [NDI+PWR_N:0]   pins_sync;
	logic                 any_err;

	// Shared pattern dividers
	slpg_blink #(
		.QUARTER (QUARTER),
		.FLICK   (FLICK)
	) u_blink (
		.ref_clk      (ref_clk),
		.rst          (rst),
		.blink_1hz    (b1),
		.blink_2hz    (b2),
		.flicker      (fl),
		.quarter_tick (qtick)
	);

	// Pin synchronisers for inputs, fault and supplies
	slpg_sync3 #(
		.W (NDI + PWR_N + 1)
	) u_sync (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.async_in ({output_section_return_fault_pin, output_section_supply_feed_pin,
			input_section_supply_feed_pin, electronics_supply_feed_pin, di_pin}),
		.sync_out (pins_sync)
	);

	assign stup_done = (stup_reg >= STUP_W'(STARTUP_TICKS));
	assign any_err   = core_error | core_sys_error;

	// Display sequencing
	always_comb
	begin
		st_next = st_reg;
		case (st_reg)
			ST_POWER_ON:
				if (core_startup)
					st_next = ST_STARTUP;
			ST_STARTUP:
				// R2 minimum start-up time
				if (!core_startup && stup_done)
					st_next = ST_OPER;
			ST_OPER:
				if (core_startup)
					st_next = ST_STARTUP;
			default:
				st_next = ST_POWER_ON;
		endcase
	end

	// State register
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			st_reg <= ST_POWER_ON;
		else
			st_reg <= st_next;
	end

	// R2 start-up time counter
	always_ff @(posedge ref_clk)
	begin
		if (rst || st_reg != ST_STARTUP)
			stup_reg <= '0;
		else if (qtick && !stup_done)
			stup_reg <= stup_reg + STUP_W'(1);
	end

	// Status bar pattern selection, highest priority first
	always_comb
	begin
		red_next = 1'b0;
		yel_next = 1'b0;
		ga_next  = 1'b0;
		gb_next  = 1'b0;
		if (st_reg == ST_POWER_ON)
			// R1 power-on blink
			yel_next = b1;
		else if (st_reg == ST_STARTUP)
		begin
			// R2 R8 start-up blink
			ga_next  = b2;
			gb_next  = b2;
			red_next = core_diag_pending & b1;
		end
		else if (fw_fail)
			// R20 update failed
			red_next = b1;
		else if (fw_done_ok || fact_done)
		begin
			// R17 R20 await power cycle
			red_next = b1;
			yel_next = b1;
		end
		else if (fw_busy)
			// R19 update progress
			yel_next = card_access ? fl : b2;
		else if (fw_new)
		begin
			// R18 opposite phase
			red_next = b1;
			yel_next = ~b1;
		end
		else if (fact_exec || mres_exec || hw_cfg_loading)
			// R11 R16 R17 yellow 2 Hz
			yel_next = b2;
		else if (mres_req)
			// R16 reset requested
			yel_next = b1;
		else if (mres_done)
			// R16 reset finished
			yel_next = 1'b1;
		else if (ctrl_reg[CTRL_TEST_BIT])
		begin
			// R12 blink test
			ga_next = b1;
			gb_next = b1;
		end
		else if (core_sys_error)
		begin
			// R9 system error
			red_next = 1'b1;
			ga_next  = 1'b1;
			gb_next  = 1'b1;
		end
		else if (core_error)
			// R4 error state
			red_next = 1'b1;
		else if (core_hold_point)
		begin
			// R7 holding point
			red_next = 1'b1;
			ga_next  = b1;
			gb_next  = b1;
		end
		else if (core_run && core_diag_pending)
		begin
			// R6 R14 diagnostics while running
			red_next = b1;
			ga_next  = card_access ? fl : 1'b1;
			gb_next  = card_access ? fl : 1'b1;
		end
		else if (core_run)
		begin
			// R5 R13 running
			ga_next = 1'b1;
			gb_next = card_access ? fl : 1'b1;
		end
		else if (core_stop)
			// R3 R15 halted
			yel_next = card_access ? fl : 1'b1;
	end

	// Status bar LED registers
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			led_red     <= 1'b0;
			led_yellow  <= 1'b0;
			led_green_a <= 1'b0;
			led_green_b <= 1'b0;
		end
		else
		begin
			led_red     <= red_next;
			led_yellow  <= yel_next;
			led_green_a <= ga_next;
			led_green_b <= gb_next;
		end
	end

	// R21 R22 channel and supply LEDs
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			di_led                         <= '0;
			do_led                         <= '0;
			electronics_supply_feed_led    <= 1'b0;
			input_section_supply_feed_led  <= 1'b0;
			output_section_supply_feed_led <= 1'b0;
			output_section_return_led      <= 1'b0;
		end
		else
		begin
			di_led                         <= pins_sync[NDI-1:0];
			do_led                         <= do_level;
			electronics_supply_feed_led    <= pins_sync[NDI];
			input_section_supply_feed_led  <= pins_sync[NDI+1];
			output_section_supply_feed_led <= pins_sync[NDI+2];
			output_section_return_led      <= pins_sync[NDI+3];
		end
	end

	// R10 diagnostic logging sequence
	always_comb
	begin
		log_next = log_reg;
		case (log_reg)
			LOG_IDLE:
				if (ctrl_reg[CTRL_LOG_BIT] && any_err && !err_prev_reg)
					log_next = LOG_WRITE;
			LOG_WRITE:
				if (card_write_done)
					log_next = LOG_RESTART;
			LOG_RESTART:
				log_next = LOG_IDLE;
			default:
				log_next = LOG_IDLE;
		endcase
	end

	// Logging state and error edge
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			log_reg      <= LOG_IDLE;
			err_prev_reg <= 1'b0;
		end
		else
		begin
			log_reg      <= log_next;
			err_prev_reg <= any_err;
		end
	end

	assign card_write_req = (log_reg == LOG_WRITE);
	assign core_restart   = (log_reg == LOG_RESTART);

	// Control register write
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			ctrl_reg <= CTRL_RESET;
		else if (reg_wr && reg_addr == REG_CTRL)
			ctrl_reg <= reg_wdata[CTRL_W-1:0];
	end

	// Read decode
	always_comb
	begin
		rdata_next = '0;
		if (!reg_rd)
			rdata_next = '0;
		else if (reg_addr == REG_CTRL)
			rdata_next = DATA_W'(ctrl_reg);
		else if (reg_addr == REG_LEDS)
			rdata_next = DATA_W'({log_reg, st_reg, led_green_b, led_green_a, led_yellow, led_red});
		else if (reg_addr == REG_DI)
			rdata_next = DATA_W'(di_led);
		else if (reg_addr == REG_DO)
			rdata_next = DATA_W'({output_section_return_led, output_section_supply_feed_led,
				input_section_supply_feed_led, electronics_supply_feed_led, do_led});
	end

	// Read data stand one cycle
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			reg_rdata <= '0;
		else
			reg_rdata <= rdata_next;
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	logic base_run;
	assign base_run = (st_reg == ST_OPER) && !(fw_fail | fw_done_ok | fact_done | fw_busy | fw_new
		| fact_exec | mres_exec | hw_cfg_loading | mres_req | mres_done | ctrl_reg[CTRL_TEST_BIT]);

	chk_power_yellow: assert property ( // R1
		!rst && st_reg == ST_POWER_ON |=> led_yellow == $past(b1) && !led_red && !led_green_a)
		else $error("power-on pattern wrong");
	chk_startup_min: assert property ( // R2
		st_reg == ST_STARTUP && !stup_done |=> st_reg == ST_STARTUP)
		else $error("start-up left too early");
	chk_stop_yellow: assert property ( // R3
		base_run && core_stop && !core_run && !any_err && !core_hold_point && !card_access
		|=> led_yellow && !led_red && !led_green_a)
		else $error("stop pattern wrong");
	chk_error_red: assert property ( // R4
		base_run && core_error && !core_sys_error |=> led_red && !led_green_a && !led_yellow)
		else $error("error pattern wrong");
	chk_run_green: assert property ( // R5
		base_run && core_run && !any_err && !core_hold_point && !core_diag_pending && !card_access
		|=> led_green_a && led_green_b && !led_red && !led_yellow)
		else $error("run pattern wrong");
	chk_run_diag: assert property ( // R6
		base_run && core_run && core_diag_pending && !any_err && !core_hold_point && !card_access
		|=> led_green_a && led_red == $past(b1))
		else $error("diagnostic run pattern wrong");
	chk_hold_point: assert property ( // R7
		base_run && core_hold_point && !any_err |=> led_red && led_green_a == $past(b1))
		else $error("holding point pattern wrong");
	chk_sys_error: assert property ( // R9
		base_run && core_sys_error |=> led_red && led_green_a && led_green_b)
		else $error("system error pattern wrong");
	chk_log_restart: assert property ( // R10
		log_reg == LOG_WRITE && card_write_done |=> core_restart ##1 !core_restart)
		else $error("restart not one cycle after card write");
	chk_fw_alternate: assert property ( // R18
		st_reg == ST_OPER && fw_new && !(fw_fail | fw_done_ok | fact_done | fw_busy)
		|=> led_red != led_yellow)
		else $error("firmware alternate blink wrong");
	chk_io_follow: assert property ( // R21
		!rst |=> di_led == $past(pins_sync[NDI-1:0]) && do_led == $past(do_level))
		else $error("channel LED does not follow level");
	chk_fault_led: assert property ( // R22
		!rst |=> output_section_return_led == $past(pins_sync[NDI+3]))
		else $error("fault LED does not follow fault");

	cov_startup_done: cover property (st_reg == ST_STARTUP ##1 st_reg == ST_OPER);
	cov_card_run: cover property (base_run && core_run && card_access);
	cov_log_cycle: cover property (log_reg == LOG_WRITE ##[1:20] core_restart);

endmodule : slpg_top

// ### verif/slpg_card_model.sv
// Memory card model that finishes logging writes after a fixed delay
module slpg_card_model
#(
	parameter int DELAY = 10
)
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// Write handshake
	input  wire logic card_write_req,
	output logic      card_write_done
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;

	// card write completion
	// Count while requested, pulse done once, rearm when request drops
	always_ff @(posedge ref_clk)
	begin
		if (rst || !card_write_req)
		begin
			cnt             <= 0;
			card_write_done <= 1'b0;
		end
		else
		begin
			card_write_done <= (cnt == DELAY - 1);
			if (cnt < DELAY)
				cnt <= cnt + 1;
		end
	end
endmodule : slpg_card_model

// ### verif/slpg_top_test.sv
// Self-checking bench of the status LED pattern generator
module slpg_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int QT = 40;
	localparam int LIMIT = 20000;
	localparam int B_STUP = 0, B_RUN = 1, B_STOP = 2, B_ERR = 3, B_SYS = 4, B_DIAG = 5, B_HOLD = 6, B_CARD = 7;
	localparam int B_HWC = 8, B_MRQ = 9, B_MRX = 10, B_MRD = 11, B_FX = 12, B_FD = 13, B_FWN = 14, B_FWB = 15;
	localparam int B_FWOK = 16, B_FWF = 17;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [17:0] st = 18'h0;
	logic [15:0] di_pin = 16'h0;
	logic [11:0] do_level = 12'h0;
	logic        flt = 1'b0, sp_e = 1'b0, sp_i = 1'b0, sp_o = 1'b0;
	logic        card_write_done, card_write_req, core_restart;
	logic        led_red, led_yellow, led_green_a, led_green_b;
	logic [15:0] di_led;
	logic [11:0] do_led;
	logic        flt_led, sp_e_led, sp_i_led, sp_o_led;
	wire  [3:0]  leds = {led_green_b, led_green_a, led_yellow, led_red};
	int          cyc = 0, tot = 0, fails = 0, n_tests = 0;

	slpg_top #(.QUARTER(QT), .FLICK(4)) uut (
		.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_startup(st[B_STUP]), .core_run(st[B_RUN]),
		.core_stop(st[B_STOP]), .core_error(st[B_ERR]), .core_sys_error(st[B_SYS]),
		.core_diag_pending(st[B_DIAG]), .core_hold_point(st[B_HOLD]), .card_access(st[B_CARD]),
		.hw_cfg_loading(st[B_HWC]), .mres_req(st[B_MRQ]), .mres_exec(st[B_MRX]), .mres_done(st[B_MRD]),
		.fact_exec(st[B_FX]), .fact_done(st[B_FD]), .fw_new(st[B_FWN]), .fw_busy(st[B_FWB]),
		.fw_done_ok(st[B_FWOK]), .fw_fail(st[B_FWF]), .card_write_done(card_write_done),
		.card_write_req(card_write_req), .core_restart(core_restart), .di_pin(di_pin), .do_level(do_level),
		.output_section_return_fault_pin(flt), .electronics_supply_feed_pin(sp_e),
		.input_section_supply_feed_pin(sp_i), .output_section_supply_feed_pin(sp_o),
		.led_red(led_red), .led_yellow(led_yellow), .led_green_a(led_green_a), .led_green_b(led_green_b),
		.di_led(di_led), .do_led(do_led), .output_section_return_led(flt_led),
		.electronics_supply_feed_led(sp_e_led), .input_section_supply_feed_led(sp_i_led),
		.output_section_supply_feed_led(sp_o_led)
	);

	slpg_card_model #(.DELAY(10)) card (.ref_clk(ref_clk), .rst(rst), .card_write_req(card_write_req),
		.card_write_done(card_write_done));

	// Clock and cycle counters; the phase counter follows the blink dividers
	initial
	begin
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cyc <= rst ? 0 : cyc + 1;
		tot <= tot + 1;
		if (tot == LIMIT)
		begin
			fails++;
			print_verdict();
		end
	end

	function automatic logic [17:0] bm(input int b);
		return 18'h1 << b;
	endfunction : bm

	// Pattern codes: 0 off, 1 on, 2 1 Hz, 3 2 Hz, 4 1 Hz in opposite phase, 5 flicker, 6 not looked at
	function automatic logic ev(input int c, input int q);
		case (c)
			0: return 1'b0;
			1: return 1'b1;
			2: return !q[1];
			3: return !q[0];
			default: return q[1];
		endcase
	endfunction : ev

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Watch the status LEDs over four quarters: level at each mid-quarter, toggles overall
	task automatic look(input string nm, input int c0, input int c1, input int c2, input int c3);
		int         c [4];
		int         tg [4];
		logic [3:0] prev;
		logic [3:0] now;
		c = '{c0, c1, c2, c3};
		tg = '{0, 0, 0, 0};
		repeat (5) @(posedge ref_clk);
		#1;
		prev = leds;
		for (int k = 0; k < 4; k++)
		begin
			do
			begin
				@(posedge ref_clk);
				#1;
				now = leds;
				for (int j = 0; j < 4; j++)
					tg[j] += int'(now[j] != prev[j]);
				prev = now;
			end while (cyc % QT != QT / 2);
			for (int j = 0; j < 4; j++)
				if (c[j] < 5)
					chk($sformatf("%s led %0d", nm, j), {31'h0, ev(c[j], cyc / QT)}, {31'h0, now[j]});
		end
		for (int j = 0; j < 4; j++)
			if (c[j] < 2)
				chk($sformatf("%s toggles %0d", nm, j), 32'h0, 32'(tg[j]));
			else if (c[j] == 5)
				chk($sformatf("%s flicker %0d", nm, j), 32'h1, {31'h0, tg[j] >= 16});
		$display("test %s done", nm);
	endtask : look

	task automatic go(input string nm, input logic [17:0] m, input int c0, input int c1, input int c2, input int c3);
		@(posedge ref_clk);
		st <= m;
		look(nm, c0, c1, c2, c3);
	endtask : go

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rdchk(input string nm, input logic [3:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(nm, e, reg_rdata);
	endtask : rdchk

	// Power-on and start-up display, start-up held after its input drops
	task automatic t_boot();
		look("power on", 0, 2, 0, 0);
		@(posedge ref_clk);
		st <= bm(B_STUP);
		repeat (2) @(posedge ref_clk);
		st <= 18'h0;
		look("startup", 0, 0, 3, 3);
		go("startup diag", bm(B_DIAG), 2, 0, 3, 3);
		go("startup held", bm(B_RUN), 0, 0, 3, 3);
		repeat (8 * QT) @(posedge ref_clk);
		look("run", 0, 0, 1, 1);
	endtask : t_boot

	// Register map, reset value, idle read data and unmapped address
	task automatic t_regs();
		@(posedge ref_clk);
		st <= bm(B_STOP);
		rdchk("ctrl reset", slpg_pkg::REG_CTRL, 32'h0);
		wr(slpg_pkg::REG_CTRL, 32'hFFFF_FFFF);
		rdchk("ctrl rw", slpg_pkg::REG_CTRL, 32'h3);
		wr(slpg_pkg::REG_CTRL, 32'h0);
		rdchk("ctrl clear", slpg_pkg::REG_CTRL, 32'h0);
		rdchk("leds stop", slpg_pkg::REG_LEDS, 32'h142);
		@(posedge ref_clk);
		#1;
		chk("rdata idle", 32'h0, reg_rdata);
		rdchk("unmapped", 4'h2, 32'h0);
		$display("test regs done");
	endtask : t_regs

	task automatic t_core();
		go("stop", bm(B_STOP), 0, 1, 0, 0);
		go("error", bm(B_ERR), 1, 0, 0, 0);
		go("run diag", bm(B_RUN) | bm(B_DIAG), 2, 0, 1, 1);
		go("hold point", bm(B_STOP) | bm(B_HOLD), 1, 0, 2, 2);
		go("sys error", bm(B_SYS) | bm(B_RUN), 1, 0, 1, 1);
		go("hw config", bm(B_HWC) | bm(B_STOP), 0, 3, 0, 0);
		go("card run", bm(B_RUN) | bm(B_CARD), 0, 0, 1, 5);
		go("card diag", bm(B_RUN) | bm(B_DIAG) | bm(B_CARD), 2, 0, 5, 5);
		go("card stop", bm(B_STOP) | bm(B_CARD), 0, 5, 0, 0);
		go("dark", 18'h0, 0, 0, 0, 0);
	endtask : t_core

	task automatic t_resets();
		go("mres req", bm(B_MRQ) | bm(B_STOP), 0, 2, 0, 0);
		go("mres exec", bm(B_MRX) | bm(B_MRQ), 0, 3, 0, 0);
		go("mres done", bm(B_MRD) | bm(B_STOP), 0, 1, 0, 0);
		go("fact exec", bm(B_FX), 0, 3, 0, 0);
		go("fact done", bm(B_FD) | bm(B_ERR), 2, 2, 0, 0);
	endtask : t_resets

	task automatic t_fw();
		go("fw new", bm(B_FWN), 2, 4, 0, 0);
		go("fw busy", bm(B_FWB) | bm(B_FWN), 0, 3, 0, 0);
		go("fw card", bm(B_FWB) | bm(B_CARD), 0, 5, 0, 0);
		go("fw ok", bm(B_FWOK) | bm(B_FWB), 2, 2, 0, 0);
		go("fw fail", bm(B_FWF) | bm(B_FWOK), 2, 0, 0, 0);
	endtask : t_fw

	task automatic t_blink_test();
		wr(slpg_pkg::REG_CTRL, 32'h2);
		go("blink test", bm(B_RUN), 0, 0, 2, 2);
		wr(slpg_pkg::REG_CTRL, 32'h0);
	endtask : t_blink_test

	// Error logging off, then on with the card answering after a delay
	task automatic t_logging();
		int seen;
		int k;
		go("pre log", bm(B_STOP), 0, 1, 0, 0);
		@(posedge ref_clk);
		st <= bm(B_ERR);
		repeat (20) @(posedge ref_clk);
		#1;
		chk("no log req", 32'h0, {31'h0, card_write_req});
		@(posedge ref_clk);
		st <= bm(B_STOP);
		wr(slpg_pkg::REG_CTRL, 32'h1);
		@(posedge ref_clk);
		st <= bm(B_ERR);
		seen = 0;
		k = 0;
		while (core_restart !== 1'b1 && k < 200)
		begin
			@(posedge ref_clk);
			#1;
			seen += int'(card_write_req === 1'b1);
			k++;
		end
		chk("log req cycles", 32'h1, {31'h0, seen >= 10 && seen <= 13});
		chk("restart", 32'h1, {31'h0, core_restart});
		@(posedge ref_clk);
		#1;
		chk("restart pulse", 32'h0, {30'h0, core_restart, card_write_req});
		@(posedge ref_clk);
		st <= bm(B_STOP);
		wr(slpg_pkg::REG_CTRL, 32'h0);
		$display("test logging done");
	endtask : t_logging

	// Channel, fault and supply LEDs with a pattern and its complement
	task automatic t_io();
		for (int i = 0; i < 2; i++)
		begin
			@(posedge ref_clk);
			di_pin <= (i == 0) ? 16'hA5C3 : 16'h5A3C;
			do_level <= (i == 0) ? 12'h5A6 : 12'hA59;
			{flt, sp_o, sp_i, sp_e} <= (i == 0) ? 4'hD : 4'h2;
			repeat (8) @(posedge ref_clk);
			#1;
			chk("di led", {16'h0, di_pin}, {16'h0, di_led});
			chk("do led", {20'h0, do_level}, {20'h0, do_led});
			chk("fault supply", {28'h0, flt, sp_o, sp_i, sp_e}, {28'h0, flt_led, sp_o_led, sp_i_led, sp_e_led});
			rdchk("di reg", slpg_pkg::REG_DI, {16'h0, di_pin});
			rdchk("do reg", slpg_pkg::REG_DO, {16'h0, flt, sp_o, sp_i, sp_e, do_level});
		end
		$display("test io done");
	endtask : t_io

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	// Main sequence
	initial
	begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		t_boot();
		t_regs();
		t_core();
		t_resets();
		t_fw();
		t_blink_test();
		t_logging();
		t_io();
		print_verdict();
	end
endmodule : slpg_top_test
